// >>> rtl/prot_sup_map.svh
`ifndef PROT_SUP_MAP_SVH
`define PROT_SUP_MAP_SVH
// interrupt pulse width
`define PS_INT_PULSE_US 256
`define PS_CLK_MHZ 100
`define PS_INT_PULSE_CYC (`PS_INT_PULSE_US * `PS_CLK_MHZ)
// boost hiccup retries and off time between tries
`define PS_HICCUP_RETRIES 7
`define PS_HICCUP_OFF_CYC 1000
// soft-start ramp length
`define PS_SOFTSTART_CYC 2000
// charge fault codes
`define PS_FAULT_NONE 2'h0
`define PS_FAULT_INPUT 2'h1
`define PS_FAULT_THERMAL 2'h2
// input over-voltage select default (second setting)
`define PS_OVSEL_DEFAULT 2'h1
// short-current charge code
`define PS_ISHORT_MA 80
`endif

// >>> rtl/prot_sup_pkg.sv
package prot_sup_pkg;
    // comparator results from the analog front end
    typedef struct packed {
        logic input_ov;      // input above selected limit
        logic input_ov_hys;  // input still above limit minus hysteresis
        logic sys_ov;        // system above min + margin
        logic boost_short;   // boost output short
        logic boost_ov;      // boost output over-voltage
        logic temp_reg;      // die at regulation temperature
        logic temp_shut;     // die above shutdown temperature
        logic temp_hys;      // die still within hysteresis band
        logic bat_ov;        // battery above regulation + margin
        logic bat_depleted;  // battery below depletion level
        logic bat_below_short; // battery below short exit threshold
        logic bat_below_low; // battery below low battery threshold
        logic bat_oc;        // battery discharge over-current
    } comp_t;
    typedef enum logic [1:0] {CHG_SHORT, CHG_PRE, CHG_FAST} chg_phase_t;
    typedef enum logic [2:0] {B_OFF, B_SOFT, B_RUN, B_HICCUP} boost_st_t;
endpackage

// >>> rtl/charger_protection_supervisor.sv
`timescale 1ns/1ps
`include "prot_sup_map.svh"
// What this block does
// - input over-voltage stops switching, selectable limit
// - input over-voltage pulses once, fault code 01
// - code clears after recovery and fault read
// - resume normally when input drops back
// - system over-voltage stops switching, enables sink
// - boost starts with soft-start each enable
// - boost short retries hiccup up to seven
// - persistent short clears enable, flags, pulses
// - host re-enable clears boost fault flag
// - boost over-voltage stops, clears enable, flags
// - thermal regulation in buck mode cuts current, sets flag
// - regulation halves timer rate, blocks termination
// - buck shutdown: converter, switch off, code 10
// - buck shutdown recovers after hysteresis
// - boost shutdown: switch back, boost waits host
// - battery over-voltage stops charge, flags, pulses
// - depletion latches switch off until input
// - short current, then programmed precharge current
// - over-current latches switch until ship exit
// - each fault (input over-voltage, buck shutdown, boost, battery over-voltage): active-low 256us interrupt pulse
// - no new fault pulse until read, cleared
module charger_protection_supervisor
    import prot_sup_pkg::*;
#(
    parameter int unsigned INT_PULSE_CYC = `PS_INT_PULSE_CYC,
    parameter int unsigned HICCUP_RETRIES = `PS_HICCUP_RETRIES,
    parameter int unsigned HICCUP_OFF_CYC = `PS_HICCUP_OFF_CYC,
    parameter int unsigned SOFTSTART_CYC = `PS_SOFTSTART_CYC
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire comp_t comp_async,                     // raw comparator levels
    input wire logic [1:0] input_overvoltage_select,  // limit choice, drives analog trim
    input wire logic [3:0] precharge_current_setting, // programmed precharge code
    input wire logic buck_mode,                       // converter in buck mode
    input wire logic input_valid,                     // valid input source present
    input wire logic ship_exit,                       // any ship-mode exit condition, pulse
    input wire logic host_boost_enable,               // host sets boost enable, pulse
    input wire logic host_boost_disable,              // host clears boost enable, pulse
    input wire logic fault_read,                      // host read of fault register, pulse
    input wire logic timer_tick,                      // safety timer base tick
    output logic [1:0] ov_limit_select,
    output logic switching_en,
    output logic sys_sink_en,
    output logic battery_switch,
    output logic boost_enable_bit,
    output logic boost_softstart,
    output logic boost_fault_flag,
    output logic battery_fault_flag,
    output logic thermal_regulation_flag,
    output logic charge_current_reduce,
    output logic [1:0] charge_fault_code,
    output logic [1:0] charge_phase,
    output logic [3:0] charge_current_code,
    output logic charge_stop,
    output logic safety_timer_tick,
    output logic termination_inhibit,
    output logic interrupt_pulse_pin_n
);
    // ******************************************
    // parameter checks
    // ******************************************
    initial
    begin
        // all counters are 16 bits wide, retries 4 bits
        if (HICCUP_RETRIES < 1 || HICCUP_RETRIES > 15 || INT_PULSE_CYC < 1 || INT_PULSE_CYC > 65535
            || SOFTSTART_CYC > 65535 || HICCUP_OFF_CYC > 65535)
            $error("unsupported parameter");
    end

    // ******************************************
    // input synchroniser, three stages
    // ******************************************
    comp_t s1_q, s2_q, s3_q, c_q; // c_q is the accepted level
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            c_q <= '0;
        end
        else
        begin
            s1_q <= comp_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a bit changes only when stages two and three agree
            c_q <= (s2_q & s3_q) | (c_q & (s2_q ^ s3_q));
        end
    end

    comp_t prev_q; // last accepted levels, for rising edges
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            prev_q <= '0;
        else
            prev_q <= c_q;
    end
    wire logic ov_rise = c_q.input_ov & ~prev_q.input_ov;
    wire logic shut_rise = c_q.temp_shut & ~prev_q.temp_shut;
    wire logic batov_rise = c_q.bat_ov & ~prev_q.bat_ov;

    // ******************************************
    // thermal shutdown latch, released by hysteresis
    // ******************************************
    logic tshut_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            tshut_q <= 1'b0;
        else if (c_q.temp_shut)
            tshut_q <= 1'b1;
        else if (!c_q.temp_hys)
            tshut_q <= 1'b0;
    end

    // ******************************************
    // battery switch latches
    // ******************************************
    logic dpl_latch_q, oc_latch_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dpl_latch_q <= 1'b0;
            oc_latch_q <= 1'b0;
        end
        else
        begin
            // input presence releases the depletion latch
            if (input_valid)
                dpl_latch_q <= 1'b0;
            else if (c_q.bat_depleted)
                dpl_latch_q <= 1'b1;
            if (c_q.bat_oc)
                oc_latch_q <= 1'b1;
            else if (ship_exit)
                oc_latch_q <= 1'b0;
        end
    end

    // ******************************************
    // boost sequencer: soft-start, run, hiccup
    // ******************************************
    boost_st_t bst_q;
    logic [15:0] bcnt_q;
    logic [3:0] tries_q;
    logic boost_kill; // one-cycle boost fault event
    logic fault_ev; // any event that may raise the interrupt
    wire logic boost_ov_ev = (bst_q != B_OFF) && c_q.boost_ov;
    wire logic boost_short_end = (bst_q == B_HICCUP) && (bcnt_q == 16'h0000)
        && (tries_q == 4'(HICCUP_RETRIES)) && c_q.boost_short;
    assign boost_kill = boost_ov_ev | boost_short_end;
    wire logic boost_shut_ev = (bst_q != B_OFF) && c_q.temp_shut;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            bst_q <= B_OFF;
            bcnt_q <= '0;
            tries_q <= '0;
        end
        else
        begin
            case (bst_q)
                B_OFF:
                    if (host_boost_enable && !buck_mode && !tshut_q)
                    begin
                        bst_q <= B_SOFT;
                        bcnt_q <= 16'(SOFTSTART_CYC);
                        tries_q <= '0;
                    end
                B_SOFT, B_RUN:
                    if (boost_ov_ev || boost_shut_ev || host_boost_disable)
                        bst_q <= B_OFF;
                    else if (c_q.boost_short)
                    begin
                        bst_q <= B_HICCUP;
                        bcnt_q <= 16'(HICCUP_OFF_CYC);
                    end
                    else if (bst_q == B_SOFT)
                    begin
                        if (bcnt_q == 16'h0000)
                            bst_q <= B_RUN;
                        else
                            bcnt_q <= bcnt_q - 16'h0001;
                    end
                B_HICCUP:
                    // over-voltage during an off period still ends boost
                    if (boost_ov_ev || boost_shut_ev || host_boost_disable || boost_short_end)
                        bst_q <= B_OFF;
                    else if (bcnt_q != 16'h0000)
                        bcnt_q <= bcnt_q - 16'h0001;
                    else if (c_q.boost_short)
                    begin
                        tries_q <= tries_q + 4'h1;
                        bcnt_q <= 16'(HICCUP_OFF_CYC);
                    end
                    else
                    begin
                        bst_q <= B_SOFT; // retry restarts softly
                        bcnt_q <= 16'(SOFTSTART_CYC);
                    end
                default:
                    bst_q <= B_OFF;
            endcase
        end
    end

    // ******************************************
    // fault flags and code
    // ******************************************
    logic [1:0] code_q;
    logic bfault_q, batfault_q, read_seen_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            code_q <= `PS_FAULT_NONE;
            bfault_q <= 1'b0;
            batfault_q <= 1'b0;
            read_seen_q <= 1'b0;
        end
        else
        begin
            // a read clears only in its own cycle, once the cause is gone; new events win over it
            if (c_q.input_ov)
                code_q <= `PS_FAULT_INPUT;
            else if (buck_mode && shut_rise)
                code_q <= `PS_FAULT_THERMAL;
            else if (fault_read && !c_q.input_ov_hys && !(code_q == `PS_FAULT_THERMAL && tshut_q))
                code_q <= `PS_FAULT_NONE;
            if (boost_kill)
                bfault_q <= 1'b1;
            else if (host_boost_enable || fault_read)
                bfault_q <= 1'b0;
            if (batov_rise)
                batfault_q <= 1'b1;
            else if (fault_read && !c_q.bat_ov)
                batfault_q <= 1'b0;
            read_seen_q <= fault_read ? 1'b1 : (fault_ev ? 1'b0 : read_seen_q);
        end
    end

    // ******************************************
    // interrupt pulse generator
    // ******************************************
    assign fault_ev = ov_rise | (buck_mode & shut_rise) | boost_kill | batov_rise;
    wire logic faults_clear = (code_q == `PS_FAULT_NONE) && !bfault_q && !batfault_q;
    logic armed_q; // fault pulses allowed
    logic [15:0] icnt_q;
    logic int_n_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            armed_q <= 1'b1;
        else if (fault_ev && armed_q)
            armed_q <= 1'b0;
        else if (read_seen_q && faults_clear)
            armed_q <= 1'b1;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            icnt_q <= '0;
            int_n_q <= 1'b1;
        end
        else if (fault_ev && armed_q && icnt_q == 16'h0000)
        begin
            icnt_q <= 16'(INT_PULSE_CYC - 1);
            int_n_q <= 1'b0;
        end
        else if (icnt_q != 16'h0000)
            icnt_q <= icnt_q - 16'h0001;
        else
            int_n_q <= 1'b1;
    end

    // ******************************************
    // power stage and charge control outputs
    // ******************************************
    logic ttick_half_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ov_limit_select <= `PS_OVSEL_DEFAULT;
            switching_en <= 1'b0;
            sys_sink_en <= 1'b0;
            battery_switch <= 1'b0;
            thermal_regulation_flag <= 1'b0;
            charge_stop <= 1'b1;
            charge_phase <= CHG_SHORT;
            charge_current_code <= '0;
            safety_timer_tick <= 1'b0;
            termination_inhibit <= 1'b0;
            ttick_half_q <= 1'b0;
        end
        else
        begin
            ov_limit_select <= input_overvoltage_select;
            // input over-voltage stops switching; lifts itself when gone
            switching_en <= !c_q.input_ov && !c_q.sys_ov && !tshut_q
                && (buck_mode || bst_q == B_SOFT || bst_q == B_RUN);
            sys_sink_en <= c_q.sys_ov;
            battery_switch <= !tshut_q && !dpl_latch_q && !oc_latch_q;
            thermal_regulation_flag <= buck_mode && c_q.temp_reg;
            charge_stop <= c_q.bat_ov || c_q.input_ov || tshut_q || !buck_mode;
            if (c_q.bat_below_short)
            begin
                charge_phase <= CHG_SHORT;
                charge_current_code <= '0;
            end
            else if (c_q.bat_below_low)
            begin
                charge_phase <= CHG_PRE;
                charge_current_code <= precharge_current_setting;
            end
            else
            begin
                charge_phase <= CHG_FAST;
                charge_current_code <= precharge_current_setting;
            end
            // pass every other tick while regulating
            if (timer_tick)
                ttick_half_q <= ~ttick_half_q;
            safety_timer_tick <= timer_tick && (!thermal_regulation_flag || ttick_half_q);
            termination_inhibit <= thermal_regulation_flag;
        end
    end
    assign charge_current_reduce = thermal_regulation_flag;
    assign boost_enable_bit = (bst_q != B_OFF);
    assign boost_softstart = (bst_q == B_SOFT);
    assign boost_fault_flag = bfault_q;
    assign battery_fault_flag = batfault_q;
    assign charge_fault_code = code_q;
    assign interrupt_pulse_pin_n = int_n_q;

    // ******************************************
    // assertions
    // ******************************************
    sequence s_kill;
        boost_kill;
    endsequence
    property p_boost_kill;
        @(posedge ref_clk) disable iff (!rst_n) s_kill |=> !boost_enable_bit && boost_fault_flag;
    endproperty
    a_boost_kill: assert property (p_boost_kill) else $error("boost fault not latched");
    property p_ov_code;
        @(posedge ref_clk) disable iff (!rst_n) c_q.input_ov |=> charge_fault_code == 2'h1;
    endproperty
    a_ov_code: assert property (p_ov_code) else $error("input fault code wrong");
    property p_ov_sw;
        @(posedge ref_clk) disable iff (!rst_n) c_q.input_ov |=> !switching_en;
    endproperty
    a_ov_sw: assert property (p_ov_sw) else $error("switching during over-voltage");
    property p_sink;
        @(posedge ref_clk) disable iff (!rst_n) c_q.sys_ov |=> sys_sink_en && !switching_en;
    endproperty
    a_sink: assert property (p_sink) else $error("sink not enabled");
    property p_int_width;
        @(posedge ref_clk) disable iff (!rst_n) $fell(interrupt_pulse_pin_n) |-> !interrupt_pulse_pin_n [*8];
    endproperty
    a_int_width: assert property (p_int_width) else $error("interrupt pulse short");
    property p_tshut;
        @(posedge ref_clk) disable iff (!rst_n) tshut_q |=> !battery_switch;
    endproperty
    a_tshut: assert property (p_tshut) else $error("switch on in shutdown");
    property p_reenable;
        @(posedge ref_clk) disable iff (!rst_n) host_boost_enable && !boost_kill |=> !boost_fault_flag;
    endproperty
    a_reenable: assert property (p_reenable) else $error("boost fault not cleared");
    property p_batov;
        @(posedge ref_clk) disable iff (!rst_n) batov_rise |=> battery_fault_flag && charge_stop;
    endproperty
    a_batov: assert property (p_batov) else $error("battery fault missed");
    property p_oc;
        @(posedge ref_clk) disable iff (!rst_n) oc_latch_q |=> !battery_switch;
    endproperty
    a_oc: assert property (p_oc) else $error("switch on after over-current");
    property p_treg;
        @(posedge ref_clk) disable iff (!rst_n) thermal_regulation_flag |=> termination_inhibit;
    endproperty
    a_treg: assert property (p_treg) else $error("termination not inhibited");
endmodule

// >>> tb/analog_front_model.sv
`timescale 1ns/1ps
// ****************************************
// comparator front end model
// ****************************************
module analog_front_model
    import prot_sup_pkg::*;
(
    input wire comp_t comp_level, // wanted comparator levels
    output comp_t comp_async      // levels as seen at the block
);
    // skewed off the clock so the block has to synchronise them
    // continuous, so the levels at time zero reach the block as well
    assign #3 comp_async = comp_level;
endmodule

// >>> tb/test_charger_protection_supervisor.sv
`timescale 1ns/1ps
module test_charger_protection_supervisor;
    import prot_sup_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam int unsigned PULSE = 20; // shortened interrupt width
    logic ref_clk = 0, rst_n = 0, buck_mode = 1, input_valid = 1, ship_exit = 0;
    logic host_boost_enable = 0, host_boost_disable = 0, fault_read = 0, timer_tick = 0;
    logic [1:0] ovsel = 2'h1, ov_limit_select, charge_fault_code, charge_phase;
    logic [3:0] pre_set = 4'h9, charge_current_code;
    logic switching_en, sys_sink_en, battery_switch, boost_enable_bit, boost_softstart;
    logic boost_fault_flag, battery_fault_flag, thermal_regulation_flag, charge_current_reduce;
    logic charge_stop, safety_timer_tick, termination_inhibit, interrupt_pulse_pin_n;
    comp_t comp_level = '0, comp_async;
    int errors = 0;
    int check_count = 0;
    int k, n_norm, n_reg;
    analog_front_model analog_front_model_inst (.comp_level(comp_level), .comp_async(comp_async));
    charger_protection_supervisor #(.INT_PULSE_CYC(PULSE), .HICCUP_RETRIES(7), .HICCUP_OFF_CYC(10),
        .SOFTSTART_CYC(10)) charger_protection_supervisor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .comp_async(comp_async), .input_overvoltage_select(ovsel), .precharge_current_setting(pre_set),
        .buck_mode(buck_mode), .input_valid(input_valid), .ship_exit(ship_exit),
        .host_boost_enable(host_boost_enable), .host_boost_disable(host_boost_disable),
        .fault_read(fault_read), .timer_tick(timer_tick), .ov_limit_select(ov_limit_select),
        .switching_en(switching_en), .sys_sink_en(sys_sink_en), .battery_switch(battery_switch),
        .boost_enable_bit(boost_enable_bit), .boost_softstart(boost_softstart),
        .boost_fault_flag(boost_fault_flag), .battery_fault_flag(battery_fault_flag),
        .thermal_regulation_flag(thermal_regulation_flag), .charge_current_reduce(charge_current_reduce),
        .charge_fault_code(charge_fault_code), .charge_phase(charge_phase),
        .charge_current_code(charge_current_code), .charge_stop(charge_stop),
        .safety_timer_tick(safety_timer_tick), .termination_inhibit(termination_inhibit),
        .interrupt_pulse_pin_n(interrupt_pulse_pin_n));
    // ****************************************
    // helpers
    // ****************************************
    // 100 MHz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // compare and report
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // step on falling edges, where inputs change
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // one-cycle pulse on the host read of the fault register
    task automatic read_fault();
        fault_read = 1;
        cyc(1);
        fault_read = 0;
        cyc(2);
    endtask
    // host write of boost enable
    task automatic boost_on();
        host_boost_enable = 1;
        cyc(1);
        host_boost_enable = 0;
    endtask
    // wait for the interrupt to fall, then measure how long it stays low
    task automatic wait_int(input int lim, output int waited);
        waited = 0;
        while (interrupt_pulse_pin_n !== 1'b0 && waited < lim)
        begin
            cyc(1);
            waited++;
        end
        check("int_fall", interrupt_pulse_pin_n, 1'b0);
        k = 0;
        while (interrupt_pulse_pin_n === 1'b0 && k < 100)
        begin
            cyc(1);
            k++;
        end
        check("int_width", k, PULSE);
    endtask
    // safety ticks passed on during 20 base ticks
    task automatic count_ticks(output int n);
        n = 0;
        timer_tick = 1;
        repeat (24)
        begin
            cyc(1);
            if (safety_timer_tick === 1'b1) n++;
            if (k++ > 18) timer_tick = 0;
        end
        timer_tick = 0;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_input_ov();
        for (int s = 0; s < 4; s++)
        begin
            ovsel = s[1:0];
            cyc(3);
            check("ov_sel", ov_limit_select, s[1:0]);
        end
        ovsel = 2'h1;
        comp_level.input_ov = 1;
        comp_level.input_ov_hys = 1;
        wait_int(20, k);
        check("sw_ov", switching_en, 1'b0);
        check("code_ov", charge_fault_code, 2'h1);
        comp_level.input_ov = 0;
        cyc(8);
        check("sw_back", switching_en, 1'b1);
        read_fault();
        check("code_hys", charge_fault_code, 2'h1);
        comp_level.input_ov_hys = 0;
        cyc(8);
        check("code_noread", charge_fault_code, 2'h1);
        read_fault();
        check("code_clr", charge_fault_code, 2'h0);
    endtask
    task automatic t_sys_ov();
        comp_level.sys_ov = 1;
        cyc(8);
        check("sink_on", {sys_sink_en, switching_en}, 2'b10);
        comp_level.sys_ov = 0;
        cyc(8);
        check("sink_off", {sys_sink_en, switching_en}, 2'b01);
    endtask
    task automatic t_boost();
        buck_mode = 0;
        cyc(2);
        boost_on();
        check("soft", {boost_enable_bit, boost_softstart}, 2'b11);
        cyc(14);
        check("soft_end", boost_softstart, 1'b0);
        comp_level.boost_short = 1;
        wait_int(1000, n_norm);
        check("retries", n_norm >= 70, 1'b1);
        check("short_off", {boost_enable_bit, boost_fault_flag}, 2'b01);
        comp_level.boost_short = 0;
        cyc(8);
        boost_on();
        check("reen", {boost_fault_flag, boost_softstart}, 2'b01);
        read_fault();
        cyc(14);
        comp_level.boost_ov = 1;
        wait_int(20, k);
        check("bov", {boost_enable_bit, boost_fault_flag}, 2'b01);
        comp_level.boost_ov = 0;
        cyc(8);
        read_fault();
        comp_level.temp_shut = 1;
        comp_level.temp_hys = 1;
        boost_on();
        cyc(8);
        check("bshut", {battery_switch, boost_enable_bit}, 2'b00);
        comp_level.temp_shut = 0;
        comp_level.temp_hys = 0;
        cyc(8);
        check("bshut_rec", {battery_switch, boost_enable_bit}, 2'b10);
        buck_mode = 1;
        read_fault();
    endtask
    task automatic t_thermal();
        k = 0;
        count_ticks(n_norm);
        comp_level.temp_reg = 1;
        cyc(8);
        check("treg", {thermal_regulation_flag, charge_current_reduce}, 2'b11);
        check("term_inh", termination_inhibit, 1'b1);
        k = 0;
        count_ticks(n_reg);
        check("half", (n_reg * 2 + 2 >= n_norm) && (n_reg * 2 <= n_norm + 2), 1'b1);
        comp_level.temp_reg = 0;
        comp_level.temp_shut = 1;
        comp_level.temp_hys = 1;
        wait_int(20, k);
        check("tshut", {charge_fault_code, battery_switch, switching_en}, 4'b1000);
        comp_level.temp_shut = 0;
        cyc(8);
        check("in_band", battery_switch, 1'b0);
        comp_level.temp_hys = 0;
        cyc(8);
        check("tshut_rec", {battery_switch, switching_en}, 2'b11);
        read_fault();
    endtask
    task automatic t_battery();
        comp_level.bat_ov = 1;
        wait_int(20, k);
        check("bat_ov", {battery_fault_flag, charge_stop}, 2'b11);
        comp_level.bat_ov = 0;
        cyc(8);
        // second fault before any read: a pulse would be low here
        comp_level.bat_ov = 1;
        cyc(10);
        check("no_repeat", interrupt_pulse_pin_n, 1'b1);
        comp_level.bat_ov = 0;
        cyc(8);
        read_fault();
        input_valid = 0;
        comp_level.bat_depleted = 1;
        cyc(8);
        comp_level.bat_depleted = 0;
        cyc(8);
        check("dpl_latch", battery_switch, 1'b0);
        input_valid = 1;
        comp_level.bat_below_short = 1;
        comp_level.bat_below_low = 1;
        cyc(8);
        check("dpl_rel", battery_switch, 1'b1);
        check("short_chg", {charge_phase, charge_current_code}, 6'h00);
        comp_level.bat_below_short = 0;
        cyc(8);
        check("pre_chg", {charge_phase, charge_current_code}, {2'h1, pre_set});
        comp_level.bat_below_low = 0;
        comp_level.bat_oc = 1;
        cyc(8);
        comp_level.bat_oc = 0;
        cyc(8);
        check("oc_latch", battery_switch, 1'b0);
        ship_exit = 1;
        cyc(1);
        ship_exit = 0;
        cyc(3);
        check("oc_rel", battery_switch, 1'b1);
    endtask
    // ****************************************
    // run
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // cut a hang short, far beyond the several hundred cycles needed
    initial
    begin
        #300000;
        errors++;
        end_of_test();
    end
    initial
    begin
        cyc(5);
        check("rst_out", {interrupt_pulse_pin_n, battery_switch, switching_en, charge_stop}, 4'b1001);
        cyc(5);
        rst_n = 1;
        cyc(10);
        t_input_ov();
        t_sys_ov();
        t_boost();
        t_thermal();
        t_battery();
        end_of_test();
    end
endmodule
